// ==== verilog/eba_area_regs.svh ====
// constants of the external bus area logic for the three lowest address areas
`ifndef EBA_AREA_REGS_SVH
`define EBA_AREA_REGS_SVH

// physical address field that picks the 64-Mbyte area
`define EBA_AREA_HI         28
`define EBA_AREA_LO         26
`define EBA_AREA0           3'h0
`define EBA_AREA1           3'h1
`define EBA_AREA2           3'h2

// bus width codes, shared by mode pins, width selects and request size
`define EBA_SZ_BYTE         2'h1
`define EBA_SZ_WORD         2'h2
`define EBA_SZ_LONG         2'h3

// log2 of byte counts
`define EBA_L2_BYTE         2'h0
`define EBA_L2_WORD         2'h1
`define EBA_L2_LONG         2'h2

// area 2 memory kind
`define EBA_MT_NORMAL       2'h0
`define EBA_MT_DRAM         2'h1
`define EBA_MT_SDRAM        2'h2

// area 0 wait code to wait cycles, 0 to 10
`define EBA_A0W_0           4'h0
`define EBA_A0W_1           4'h1
`define EBA_A0W_2           4'h2
`define EBA_A0W_3           4'h3
`define EBA_A0W_4           4'h4
`define EBA_A0W_5           4'h6
`define EBA_A0W_6           4'h8
`define EBA_A0W_7           4'ha

// least burst pitch in cycles
`define EBA_MIN_PITCH       4'h2

// idle levels
`define EBA_CS_IDLE         3'h7
`define EBA_WE_IDLE         4'hf

`endif

// ==== verilog/eba_area_pkg.sv ====
// types of the external bus area logic
package eba_area_pkg;

    // bus cycle sequencer, gray along idle-strobe-gap-done
    typedef enum logic [1:0] {
        EBA_IDLE   = 2'h0,
        EBA_STROBE = 2'h1,
        EBA_GAP    = 2'h3,
        EBA_DONE   = 2'h2
    } eba_state_t;

    // all state of the area controller
    typedef struct packed {
        eba_state_t  st;
        logic [1:0]  boot_w;
        logic        wr;
        logic        burst;
        logic        honor;
        logic        dram;
        logic [1:0]  acc_l2;
        logic [1:0]  bpb_l2;
        logic [1:0]  port_l2;
        logic [1:0]  beats_m1;
        logic [1:0]  beat;
        logic [3:0]  cnt;
        logic [3:0]  pitch;
        logic [3:0]  waits;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic        err;
        logic [2:0]  cs_n;
        logic        rd_n;
        logic [3:0]  we_n;
        logic [31:0] maddr;
        logic [31:0] dout;
        logic        doe;
    } eba_regs_t;

endpackage

// ==== verilog/eba_area_ctrl.sv ====
// area decode, strobes, waits and little-endian lane steering for areas 0 to 2
`timescale 1ns/1ps
`default_nettype none
`include "eba_area_regs.svh"

module eba_area_ctrl
(
    // clock and reset
    input  wire logic        MCLK_I,
    input  wire logic        SRST_I,
    // mode pins, caught during reset
    input  wire logic        BOOT_WIDTH_PIN_LO_I,
    input  wire logic        BOOT_WIDTH_PIN_HI_I,
    // configuration bits
    input  wire logic [2:0]  AREA0_WAIT_COUNT_I,
    input  wire logic [1:0]  MID_AREAS_WAIT_COUNT_I,
    input  wire logic [1:0]  AREA1_WIDTH_SEL_I,
    input  wire logic [1:0]  AREA2_WIDTH_SEL_I,
    input  wire logic [1:0]  AREA2_MEM_TYPE_I,
    input  wire logic        DYN_MEM_WIDTH_BIT_I,
    // request side
    input  wire logic        REQ_I,
    input  wire logic [31:0] ADDR_I,
    input  wire logic        WRITE_I,
    input  wire logic [1:0]  SIZE_I,
    input  wire logic        BURST_I,
    input  wire logic [31:0] WDATA_I,
    output logic             REQ_READY_O,
    output logic             ACK_O,
    output logic             AREA_ERR_O,
    output logic [31:0]      RDATA_O,
    // external memory side
    output logic             AREA0_SELECT_N_O,
    output logic             AREA1_SELECT_N_O,
    output logic             AREA2_SELECT_N_O,
    output logic             RD_N_O,
    output logic [3:0]       BYTE_WRITE_STROBES_N_O,
    output logic [31:0]      MEM_ADDR_O,
    output logic [31:0]      D_O,
    output logic             D_OE_O,
    input  wire logic [31:0] D_I,
    input  wire logic        WAIT_N_I
);
    import eba_area_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decoding helpers

    // width code to log2 of bytes; the reserved code acts as longword
    function automatic logic [1:0] size_l2(input logic [1:0] code);
        unique case (code)
            `EBA_SZ_BYTE: size_l2 = `EBA_L2_BYTE;
            `EBA_SZ_WORD: size_l2 = `EBA_L2_WORD;
            default:      size_l2 = `EBA_L2_LONG;
        endcase
    endfunction

    // low-bits mask of a power-of-two byte count
    function automatic logic [3:0] bytes_mask(input logic [1:0] l2);
        unique case (l2)
            `EBA_L2_BYTE: bytes_mask = 4'h1;
            `EBA_L2_WORD: bytes_mask = 4'h3;
            default:      bytes_mask = 4'hf;
        endcase
    endfunction

    // area 0 wait code to cycles
    function automatic logic [3:0] area0_waits(input logic [2:0] code);
        unique case (code)
            3'h0:    area0_waits = `EBA_A0W_0;
            3'h1:    area0_waits = `EBA_A0W_1;
            3'h2:    area0_waits = `EBA_A0W_2;
            3'h3:    area0_waits = `EBA_A0W_3;
            3'h4:    area0_waits = `EBA_A0W_4;
            3'h5:    area0_waits = `EBA_A0W_5;
            3'h6:    area0_waits = `EBA_A0W_6;
            default: area0_waits = `EBA_A0W_7;
        endcase
    endfunction

    // byte lane mask to a 32-bit data mask
    function automatic logic [31:0] lane_bits(input logic [3:0] lanes);
        lane_bits = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
    endfunction

    // lane of an address inside its port: none for bytes, bit 0 for words
    function automatic logic [1:0] port_lane(input logic [1:0] a, input logic [1:0] l2);
        unique case (l2)
            `EBA_L2_BYTE: port_lane = 2'h0;
            `EBA_L2_WORD: port_lane = {1'b0, a[0]};
            default:      port_lane = a;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    eba_regs_t  s_q;          // registered state
    eba_regs_t  s_d;          // next state
    logic [2:0] area;         // decoded area of the incoming request
    logic [1:0] port_sel;     // width code of the addressed port
    logic       load;         // set up the outputs of beat s_d.beat
    logic [1:0] off;          // byte offset of the beat inside the access
    logic [1:0] lane;         // first lane used by the beat
    logic [3:0] strobes;      // lanes used by the beat
    logic [31:0] rd_bytes;    // read bytes of the finishing beat

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    // one pass builds the whole next state; the register only copies it
    always_comb
    begin
        s_d      = s_q;
        load     = 1'b0;
        area     = ADDR_I[`EBA_AREA_HI:`EBA_AREA_LO];    // bits 31..29 ignored
        port_sel = s_q.boot_w;                           // area 0 from mode pins
        off      = 2'h0;
        lane     = 2'h0;
        strobes  = 4'h0;
        // bytes of the current beat back in access order
        off      = s_q.beat << s_q.bpb_l2;
        lane     = port_lane(s_q.maddr[1:0], s_q.port_l2);
        strobes  = bytes_mask(s_q.bpb_l2) << lane;
        // lanes outside the beat are masked, so a floating lane
        // cannot leak into the read value
        rd_bytes = ((D_I & lane_bits(strobes)) >> {lane, 3'h0}) << {off, 3'h0};

        unique case (s_q.st)
            // wait for a request and decode it
            EBA_IDLE:
            begin
                if (REQ_I)
                begin
                    // request and config are caught here, so a later input
                    // change cannot reshape a cycle already on the pins
                    s_d.addr   = ADDR_I;
                    s_d.wr     = WRITE_I;
                    s_d.wdata  = WDATA_I;
                    s_d.rdata  = 32'h0;
                    s_d.acc_l2 = size_l2(SIZE_I);
                    s_d.beat   = 2'h0;
                    s_d.honor  = 1'b1;
                    s_d.dram   = 1'b0;
                    s_d.burst  = 1'b0;
                    unique case (area)
                        `EBA_AREA0:
                        begin
                            s_d.waits = area0_waits(AREA0_WAIT_COUNT_I);
                            s_d.burst = BURST_I & ~WRITE_I;
                        end
                        `EBA_AREA1:
                        begin
                            port_sel  = AREA1_WIDTH_SEL_I;
                            s_d.waits = {2'h0, MID_AREAS_WAIT_COUNT_I};
                        end
                        `EBA_AREA2:
                        begin
                            port_sel  = AREA2_WIDTH_SEL_I;
                            s_d.waits = {2'h0, MID_AREAS_WAIT_COUNT_I};
                            if (AREA2_MEM_TYPE_I == `EBA_MT_DRAM)
                            begin
                                port_sel  = `EBA_SZ_WORD;
                                s_d.honor = 1'b0;
                                s_d.dram  = 1'b1;
                            end
                            else if (AREA2_MEM_TYPE_I == `EBA_MT_SDRAM)
                            begin
                                // long unless software misprograms the bit
                                port_sel  = DYN_MEM_WIDTH_BIT_I ? `EBA_SZ_LONG
                                                                : `EBA_SZ_WORD;
                                s_d.honor = 1'b0;
                                s_d.dram  = 1'b1;
                            end
                        end
                        default:
                        begin
                            s_d.waits = 4'h0;
                        end
                    endcase
                    s_d.port_l2 = size_l2(port_sel);
                    // beat size is the narrower of access and port
                    s_d.bpb_l2   = (s_d.acc_l2 < s_d.port_l2) ? s_d.acc_l2 : s_d.port_l2;
                    // a narrow port splits the access into 2 or 4 beats
                    s_d.beats_m1 = 2'((3'h1 << (s_d.acc_l2 - s_d.bpb_l2)) - 3'h1);
                    s_d.pitch    = (s_d.waits < `EBA_MIN_PITCH) ? `EBA_MIN_PITCH
                                                                : s_d.waits;
                    if (area > `EBA_AREA2)
                    begin
                        // outside this block: no bus cycle, flag it
                        // no select is raised, so the far side never sees it
                        s_d.err = 1'b1;
                        s_d.st  = EBA_DONE;
                    end
                    else
                    begin
                        s_d.cs_n = ~(3'h1 << area);
                        s_d.st   = EBA_STROBE;
                        load     = 1'b1;
                    end
                end
            end
            // strobes active, count waits then honour the wait input, except for dram kinds
            EBA_STROBE:
            begin
                // programmed waits run first; the wait input is read only
                // after them, so it stretches a cycle and never shortens it
                if (s_q.cnt != 4'h0)
                begin
                    s_d.cnt = s_q.cnt - 4'h1;
                end
                else if (!s_q.honor || WAIT_N_I)
                begin
                    // read data is taken on the last strobe cycle, once settled
                    if (!s_q.wr)
                    begin
                        s_d.rdata = s_q.rdata | rd_bytes;
                    end
                    if (s_q.burst && (s_q.beat != s_q.beats_m1))
                    begin
                        // burst beats follow back to back at the pitch
                        s_d.beat = s_q.beat + 2'h1;
                        load     = 1'b1;
                    end
                    else
                    begin
                        s_d.rd_n = 1'b1;
                        s_d.we_n = `EBA_WE_IDLE;
                        s_d.st   = EBA_GAP;
                    end
                end
            end
            // strobes released, select held; next beat or finish
            EBA_GAP:
            begin
                // the gap gives slow parts turn-off time between beats
                if (s_q.beat != s_q.beats_m1)
                begin
                    s_d.beat = s_q.beat + 2'h1;
                    s_d.st   = EBA_STROBE;
                    load     = 1'b1;
                end
                else
                begin
                    s_d.cs_n = `EBA_CS_IDLE;
                    s_d.doe  = 1'b0;
                    s_d.st   = EBA_DONE;
                end
            end
            // one-cycle acknowledge
            EBA_DONE:
            begin
                s_d.err = 1'b0;
                s_d.st  = EBA_IDLE;
            end
        endcase

        // drive address, lanes and strobes of the beat being set up
        if (load)
        begin
            off       = s_d.beat << s_d.bpb_l2;
            s_d.maddr = s_d.addr + {30'h0, off};
            lane      = port_lane(s_d.maddr[1:0], s_d.port_l2);
            strobes   = bytes_mask(s_d.bpb_l2) << lane;
            // only the used lanes carry data
            s_d.dout  = ((s_d.wdata >> {off, 3'h0}) << {lane, 3'h0}) & lane_bits(strobes);
            // the data pins are driven only for writes
            s_d.doe   = s_d.wr;
            // dram kinds keep the normal strobes idle
            s_d.we_n  = (s_d.wr && !s_d.dram) ? ~strobes : `EBA_WE_IDLE;
            s_d.rd_n  = s_d.wr | s_d.dram;
            // later burst beats last the pitch: the count plus the closing cycle
            s_d.cnt   = (s_d.burst && s_d.beat != 2'h0) ? s_d.pitch - 4'h1
                                                        : s_d.waits;
        end

        // synchronous reset; mode pins are caught while it is held
        if (SRST_I)
        begin
            // every pin goes idle, so nothing is selected while
            // the mode pins settle
            s_d        = '0;
            s_d.st     = EBA_IDLE;
            s_d.boot_w = {BOOT_WIDTH_PIN_HI_I, BOOT_WIDTH_PIN_LO_I};
            s_d.cs_n   = `EBA_CS_IDLE;
            s_d.rd_n   = 1'b1;
            s_d.we_n   = `EBA_WE_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    // no reset term here, the next-state logic already folds it in
    always_ff @(posedge MCLK_I)
    begin
        s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // the pins change only on the clock, so the far side never
    // sees a glitch on a select or a strobe
    // handshakes straight from the state, data from flops
    assign REQ_READY_O            = (s_q.st == EBA_IDLE);
    assign ACK_O                  = (s_q.st == EBA_DONE);
    assign AREA_ERR_O             = s_q.err;
    assign RDATA_O                = s_q.rdata;
    assign AREA0_SELECT_N_O       = s_q.cs_n[0];
    assign AREA1_SELECT_N_O       = s_q.cs_n[1];
    assign AREA2_SELECT_N_O       = s_q.cs_n[2];
    assign RD_N_O                 = s_q.rd_n;
    assign BYTE_WRITE_STROBES_N_O = s_q.we_n;
    assign MEM_ADDR_O             = s_q.maddr;
    assign D_O                    = s_q.dout;
    assign D_OE_O                 = s_q.doe;

endmodule
`default_nettype wire

// ==== sim/eba_area_ctrl_properties.sv ====
// port assertions of the area controller
`timescale 1ns/1ps
`default_nettype none
`include "eba_area_regs.svh"
module eba_area_ctrl_properties
(
    // clock, reset and configuration
    input wire logic        MCLK_I,
    input wire logic        SRST_I,
    input wire logic [2:0]  AREA0_WAIT_COUNT_I,
    input wire logic [1:0]  MID_AREAS_WAIT_COUNT_I,
    input wire logic [1:0]  AREA1_WIDTH_SEL_I,
    // request side
    input wire logic        REQ_I,
    input wire logic [31:0] ADDR_I,
    input wire logic        REQ_READY_O,
    input wire logic        ACK_O,
    input wire logic        AREA_ERR_O,
    // memory side
    input wire logic        AREA0_SELECT_N_O,
    input wire logic        AREA1_SELECT_N_O,
    input wire logic        AREA2_SELECT_N_O,
    input wire logic        RD_N_O,
    input wire logic [3:0]  BYTE_WRITE_STROBES_N_O,
    input wire logic        D_OE_O,
    input wire logic        WAIT_N_I
);
    logic [2:0] area_q;   // area of the access in flight
    wire  logic take = REQ_I && REQ_READY_O;
    wire  logic strb = !RD_N_O || (BYTE_WRITE_STROBES_N_O != `EBA_WE_IDLE);
    wire  logic [2:0] sels = {AREA2_SELECT_N_O, AREA1_SELECT_N_O, AREA0_SELECT_N_O};
    ////////////////////////////////////////////////////////////////////////
    // keep the area, since the address input moves on after the take
    always_ff @(posedge MCLK_I)
    begin
        if (SRST_I)
            area_q <= 3'h0;
        else if (take)
            area_q <= ADDR_I[28:26];
    end
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (SRST_I);
    ////////////////////////////////////////////////////////////////////////
    a_one_select: assert property ($countones(sels) >= 2)
        else $error("two area selects low together");
    a_idle_quiet: assert property (REQ_READY_O |-> sels == 3'h7 && RD_N_O && !D_OE_O
        && BYTE_WRITE_STROBES_N_O == `EBA_WE_IDLE) else $error("pins active while idle");
    a_area0_map: assert property (!AREA0_SELECT_N_O |-> area_q == 3'h0)
        else $error("area 0 select outside area 0");
    a_area1_map: assert property (!AREA1_SELECT_N_O |-> area_q == 3'h1)
        else $error("area 1 select outside area 1");
    a_area2_map: assert property (!AREA2_SELECT_N_O |-> area_q == 3'h2)
        else $error("area 2 select outside area 2");
    a_bad_area: assert property (take && ADDR_I[28:26] > 3'h2 |=> ACK_O && AREA_ERR_O)
        else $error("out of area request not refused");
    a_byte_lane: assert property (!AREA1_SELECT_N_O && AREA1_WIDTH_SEL_I == `EBA_SZ_BYTE
        |-> BYTE_WRITE_STROBES_N_O inside {4'hf, 4'he}) else $error("byte port off lane 0");
    a_min_cycle: assert property (take && ADDR_I[28:26] <= 3'h2 |=> !ACK_O [*2])
        else $error("bus cycle too short");
    a_area0_wait: assert property ($rose(strb) && area_q == 3'h0 && AREA0_WAIT_COUNT_I == 3'h7
        |-> ##10 strb) else $error("area 0 strobe shorter than ten waits");
    a_mid_wait: assert property ($rose(strb) && area_q == 3'h1 && MID_AREAS_WAIT_COUNT_I == 2'h3
        |-> strb [*4]) else $error("area 1 strobe shorter than three waits");
    a_wait_extend: assert property (strb && !WAIT_N_I |=> strb)
        else $error("strobe ended while wait held");
endmodule
bind eba_area_ctrl eba_area_ctrl_properties chk_u (.MCLK_I, .SRST_I, .AREA0_WAIT_COUNT_I,
    .MID_AREAS_WAIT_COUNT_I, .AREA1_WIDTH_SEL_I, .REQ_I, .ADDR_I, .REQ_READY_O, .ACK_O,
    .AREA_ERR_O, .AREA0_SELECT_N_O, .AREA1_SELECT_N_O, .AREA2_SELECT_N_O, .RD_N_O,
    .BYTE_WRITE_STROBES_N_O, .D_OE_O, .WAIT_N_I);
`default_nettype wire

// ==== sim/eba_mem_model.sv ====
// behavioural external memory with wait generator and write log
`timescale 1ns/1ps
`default_nettype none
module eba_mem_model
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // memory pins
    input  wire logic [2:0]  sel_n_i,
    input  wire logic        rd_n_i,
    input  wire logic [3:0]  we_n_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [31:0] wd_i,
    input  wire logic [3:0]  stall_i,
    output logic [31:0]      rd_o,
    output logic             wait_n_o
);
    logic [7:0]  mem [4][256];  // one byte store per lane
    logic [31:0] last_q;        // last value on the bus
    logic [3:0]  hold_q;        // cycles since selection began
    logic [3:0]  pwe_q;         // strobes one cycle back
    logic [31:0] log_a [16];    // beat address log
    logic [31:0] log_d [16];    // beat data log
    logic [3:0]  log_w [16];    // beat strobe log
    int          n_log;         // beats logged
    wire  logic  act = sel_n_i != 3'h7;
    wire  logic [7:0] a = addr_i[7:0];
    ////////////////////////////////////////////////////////////////////////
    // bus not read shows the inverse of its last value, so stale data never matches
    assign rd_o = (act && !rd_n_i) ? {mem[3][a], mem[2][a], mem[1][a], mem[0][a]} : ~last_q;
    // wait held low for the first stall cycles of a selection
    assign wait_n_o = !(act && hold_q < stall_i);
    always_ff @(posedge clk_i)
    begin
        last_q <= rst_i ? 32'h0 : rd_o;
        pwe_q  <= we_n_i;
        hold_q <= !act ? 4'h0 : hold_q + {3'h0, hold_q != 4'hf};
        if (rst_i)
            n_log <= 0;
        else if (act && we_n_i != 4'hf)
        begin
            for (int i = 0; i < 4; i++)
                if (!we_n_i[i])
                    mem[i][a] <= wd_i[8*i +: 8];
            if (pwe_q == 4'hf)
            begin
                log_a[n_log % 16] <= addr_i;
                log_d[n_log % 16] <= wd_i;
                log_w[n_log % 16] <= we_n_i;
                n_log <= n_log + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/eba_area_ctrl_tb_top.sv ====
// bench of the area controller against a behavioural memory
`timescale 1ns/1ps
`default_nettype none
`include "eba_area_regs.svh"
module eba_area_ctrl_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        req = 1'b0;
    logic        wr = 1'b0;
    logic        bst = 1'b0;
    logic [2:0]  a0w = 3'h0;
    logic [1:0]  mw = 2'h0;
    logic [1:0]  mtyp = `EBA_MT_NORMAL;
    logic [1:0]  sz = 2'h0;
    logic [31:0] addr = 32'h0;
    logic [31:0] wd = 32'h0;
    logic [3:0]  stall = 4'h0;
    logic [1:0]  boot = 2'h2;   // mode pins {hi, lo}
    logic [31:0] rd_q;          // read data of last access
    logic        er_q;          // area error of last access
    int          err_count = 0;
    int          n_tests = 0;
    wire logic        ready, ack, err, rd_n, doe, wait_n;
    wire logic [2:0]  sel_n;
    wire logic [3:0]  we_n;
    wire logic [31:0] rdata, maddr, dout, din;
    ////////////////////////////////////////////////////////////////////////
    // area 0 boots as a 16-bit port, area 1 bytes, area 2 longwords
    eba_area_ctrl dut_u (.MCLK_I(clk), .SRST_I(rst), .BOOT_WIDTH_PIN_LO_I(boot[0]),
        .BOOT_WIDTH_PIN_HI_I(boot[1]), .AREA0_WAIT_COUNT_I(a0w), .MID_AREAS_WAIT_COUNT_I(mw),
        .AREA1_WIDTH_SEL_I(`EBA_SZ_BYTE), .AREA2_WIDTH_SEL_I(`EBA_SZ_LONG),
        .AREA2_MEM_TYPE_I(mtyp), .DYN_MEM_WIDTH_BIT_I(1'b1), .REQ_I(req), .ADDR_I(addr),
        .WRITE_I(wr), .SIZE_I(sz), .BURST_I(bst), .WDATA_I(wd), .REQ_READY_O(ready),
        .ACK_O(ack), .AREA_ERR_O(err), .RDATA_O(rdata), .AREA0_SELECT_N_O(sel_n[0]),
        .AREA1_SELECT_N_O(sel_n[1]), .AREA2_SELECT_N_O(sel_n[2]), .RD_N_O(rd_n),
        .BYTE_WRITE_STROBES_N_O(we_n), .MEM_ADDR_O(maddr), .D_O(dout), .D_OE_O(doe),
        .D_I(din), .WAIT_N_I(wait_n));
    eba_mem_model mdl_u (.clk_i(clk), .rst_i(rst), .sel_n_i(sel_n), .rd_n_i(rd_n),
        .we_n_i(we_n), .addr_i(maddr), .wd_i(dout), .stall_i(stall), .rd_o(din),
        .wait_n_o(wait_n));
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    // one access from take to ack; cyc counts the take cycle as one
    task automatic acc(input logic [31:0] a, input logic w, input logic [1:0] s,
                       input logic b, input logic [31:0] d, output int cyc);
        req <= 1'b1;
        addr <= a;
        wr <= w;
        sz <= s;
        bst <= b;
        wd <= d;
        @(posedge clk);
        req <= 1'b0;
        cyc = 1;
        // an out-of-area request answers right after the take
        #1;
        while (ack !== 1'b1 && cyc < 80)
        begin
            @(posedge clk);
            cyc++;
            #1;
        end
        if (cyc >= 80)
        begin
            err_count++;
            tally_and_finish();
        end
        rd_q = rdata;
        er_q = err;
        @(posedge clk);
    endtask
    task automatic beat(input int k, input logic [31:0] a, input logic [3:0] w,
                        input logic [31:0] d);
        chk("beat address", a, mdl_u.log_a[k % 16]);
        chk("beat strobes", {28'h0, w}, {28'h0, mdl_u.log_w[k % 16]});
        chk("beat data", d, mdl_u.log_d[k % 16]);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic s_lanes16;
        int n;
        int c;
        n = mdl_u.n_log;
        acc(32'h2000_0001, 1'b1, `EBA_SZ_BYTE, 1'b0, 32'h5a, c);
        beat(n, 32'h2000_0001, 4'hd, 32'h5a00);
        acc(32'h0000_0004, 1'b1, `EBA_SZ_LONG, 1'b0, 32'h4433_2211, c);
        chk("long cycles", 5, c);
        beat(n + 1, 32'h4, 4'hc, 32'h2211);
        beat(n + 2, 32'h6, 4'hc, 32'h4433);
        acc(32'h0000_0004, 1'b0, `EBA_SZ_LONG, 1'b0, 32'h0, c);
        chk("long read", 32'h4433_2211, rd_q);
    endtask
    task automatic s_lanes8;
        int n;
        int c;
        n = mdl_u.n_log;
        acc(32'h0400_0003, 1'b1, `EBA_SZ_BYTE, 1'b0, 32'h77, c);
        beat(n, 32'h0400_0003, 4'he, 32'h77);
        acc(32'h0400_0012, 1'b1, `EBA_SZ_WORD, 1'b0, 32'hbbaa, c);
        beat(n + 1, 32'h0400_0012, 4'he, 32'haa);
        beat(n + 2, 32'h0400_0013, 4'he, 32'hbb);
        acc(32'h0400_0020, 1'b1, `EBA_SZ_LONG, 1'b0, 32'h8877_6655, c);
        chk("long cycles", 9, c);
        for (int k = 0; k < 4; k++)
            beat(n + 3 + k, 32'h0400_0020 + k, 4'he, (32'h8877_6655 >> (8 * k)) & 32'hff);
        acc(32'h0400_0020, 1'b0, `EBA_SZ_LONG, 1'b0, 32'h0, c);
        chk("long read", 32'h8877_6655, rd_q);
        acc(32'h0c00_0000, 1'b1, `EBA_SZ_BYTE, 1'b0, 32'h1, c);
        chk("area error", 32'h1, {31'h0, er_q});
        chk("log count", n + 7, mdl_u.n_log);
    endtask
    task automatic s_area2;
        int n;
        int c;
        n = mdl_u.n_log;
        acc(32'h6800_0040, 1'b1, `EBA_SZ_LONG, 1'b0, 32'hcafe_f00d, c);
        beat(n, 32'h6800_0040, 4'h0, 32'hcafe_f00d);
        stall <= 4'h5;
        mtyp <= `EBA_MT_DRAM;
        acc(32'h0800_0040, 1'b1, `EBA_SZ_LONG, 1'b0, 32'h1234, c);
        chk("dram cycles", 5, c);
        mtyp <= `EBA_MT_SDRAM;
        acc(32'h0800_0040, 1'b0, `EBA_SZ_LONG, 1'b0, 32'h0, c);
        chk("sdram cycles", 3, c);
        chk("log count", n + 1, mdl_u.n_log);
        mtyp <= `EBA_MT_NORMAL;
        acc(32'h0800_0040, 1'b0, `EBA_SZ_LONG, 1'b0, 32'h0, c);
        chk("waited cycles", 8, c);
        chk("long read", 32'hcafe_f00d, rd_q);
        stall <= 4'h0;
    endtask
    task automatic s_waits;
        int c;
        int w0[8] = '{0, 1, 2, 3, 4, 6, 8, 10};
        for (int k = 0; k < 8; k++)
        begin
            a0w <= k[2:0];
            acc(32'h0000_0010, 1'b0, `EBA_SZ_BYTE, 1'b0, 32'h0, c);
            chk("area 0 cycles", w0[k] + 3, c);
        end
        for (int k = 0; k < 4; k++)
        begin
            mw <= k[1:0];
            acc(32'h0400_0003, 1'b0, `EBA_SZ_BYTE, 1'b0, 32'h0, c);
            chk("area 1 cycles", k + 3, c);
            chk("byte read", 32'h77, rd_q);
        end
        a0w <= 3'h3;
        acc(32'h0000_0004, 1'b0, `EBA_SZ_LONG, 1'b1, 32'h0, c);
        chk("burst cycles", 9, c);
        chk("burst read", 32'h4433_2211, rd_q);
        a0w <= 3'h1;
        acc(32'h0000_0004, 1'b0, `EBA_SZ_LONG, 1'b1, 32'h0, c);
        chk("short burst cycles", 6, c);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        boot <= 2'h1; // area 0 keeps the width caught in reset
        @(posedge clk);
        s_lanes16();
        s_lanes8();
        s_area2();
        s_waits();
        tally_and_finish();
    end
endmodule
`default_nettype wire
